// ---- hdl/afsr_pkg.sv ----
// Package for the feature-setting and reset-report command block.
// Assumes one drive clock; task-file offsets are the host I/O addresses.
package afsr_pkg;
  // Task-file offsets
  localparam logic [9:0] OFS_FEATURE_SELECT = 10'h1F1;
  localparam logic [9:0] OFS_FAULT_REPORT = 10'h1F1;
  localparam logic [9:0] OFS_SECTOR_COUNT = 10'h1F2;
  localparam logic [9:0] OFS_SECTOR_INDEX = 10'h1F3;
  localparam logic [9:0] OFS_TRACK_LOW = 10'h1F4;
  localparam logic [9:0] OFS_TRACK_HIGH = 10'h1F5;
  localparam logic [9:0] OFS_DEVICE_HEAD = 10'h1F6;
  localparam logic [9:0] OFS_COMMAND_CODE = 10'h1F7;
  localparam logic [9:0] OFS_DRIVE_CONDITION = 10'h1F7;
  // Command codes
  localparam logic [7:0] CMD_IDENTIFY = 8'hEC;
  localparam logic [7:0] CMD_IDENTIFY_DMA = 8'hEE;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  // Feature codes
  localparam logic [7:0] FC_WCACHE_ON = 8'h02;
  localparam logic [7:0] FC_XFER_MODE = 8'h03;
  localparam logic [7:0] FC_APM_ON = 8'h05;
  localparam logic [7:0] FC_AAM_ON = 8'h42;
  localparam logic [7:0] FC_RCACHE_OFF = 8'h55;
  localparam logic [7:0] FC_KEEP_ON_SRST = 8'h66;
  localparam logic [7:0] FC_WCACHE_OFF = 8'h82;
  localparam logic [7:0] FC_APM_OFF = 8'h85;
  localparam logic [7:0] FC_RCACHE_ON = 8'hAA;
  localparam logic [7:0] FC_ECC4 = 8'hBB;
  localparam logic [7:0] FC_AAM_OFF = 8'hC2;
  localparam logic [7:0] FC_REVERT_ON_SRST = 8'hCC;
  // Transfer-mode types (upper five bits of sector count)
  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FC = 5'h01;
  localparam logic [4:0] XT_MDMA = 5'h04;
  localparam logic [4:0] XT_UDMA = 5'h08;
  localparam logic [2:0] XM_PIO_MAX = 3'h4;
  localparam logic [2:0] XM_MDMA_MAX = 3'h2;
  localparam logic [2:0] XM_UDMA_MAX = 3'h5;
  // Status and fault bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int FR_ABRT = 2;
  localparam int DH_UNIT = 4;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h50;
  localparam logic [7:0] RST_AAM_LEVEL = 8'hFE;
  localparam logic RST_RCACHE = 1'b1;
  localparam logic RST_WCACHE = 1'b1;
  localparam logic RST_APM = 1'b0;
  localparam logic RST_AAM = 1'b0;
  localparam logic RST_ECC4 = 1'b0;
  localparam logic RST_KEEP = 1'b0;
  localparam logic [7:0] RST_XFER = 8'h00;
  // Reset report layout
  localparam int RR_CABLE = 13;
  localparam int RR_D1_PDIAG = 11;
  localparam int RR_D1_METH = 9;
  localparam int RR_D0_RESP = 6;
  localparam int RR_D0_DASP = 5;
  localparam int RR_D0_PDIAG = 4;
  localparam int RR_D0_DIAG = 3;
  localparam int RR_D0_METH = 1;
  localparam logic [15:0] RR_FIXED = 16'h4001;
  // Identify word numbers served by this block
  localparam logic [7:0] IDW_RESET = 8'd93;
  localparam logic [7:0] IDW_AAM = 8'd94;
  localparam logic [7:0] IDW_EN86 = 8'd86;
  localparam int W86_AAM = 9;
  localparam int W86_APM = 3;
  // Task-file access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } afsr_bus_s;
  // Strap and reset-sense inputs
  typedef struct packed {
    logic unit1;
    logic [1:0] method;
    logic cable80;
    logic pdiag;
    logic dasp;
    logic diag_ok;
    logic resp_d1;
  } afsr_strap_s;
  typedef enum logic [1:0] {
    AFSR_IDLE,
    AFSR_BUSY,
    AFSR_DONE
  } afsr_state_e;
endpackage : afsr_pkg

// ---- hdl/afsr_core.sv ----
// Feature-setting command interpreter and reset-report identify words.
// Assumes host task-file strobes are synchronous one-cycle pulses and that
// reset-sense pins are raw pins, synchronised here.
//
// Behaviour
// - reset word bits 12-0 change only in hard reset
// - bit 13 reports 80-conductor cable sensed
// - unit 0 zeros bits 12 to 8
// - unit 1 bit 11 PDIAG, bit 12 zero
// - unit 1 bits 10-9 unit-number method
// - unit 1 zeros bits 7 to 0
// - unit 0 bit 6 responds for unit 1
// - unit 0 bits 5,4 DASP and PDIAG seen
// - unit 0 bit 3 diagnostics passed
// - unit 0 bits 2-1 unit-number method
// - word 94 low byte is acoustic level
// - code EE acts as identify without DMA
// - code EF: busy, latch feature, done, interrupt
// - unsupported feature aborts with fault bit
// - transfer mode never removes PIO4/DMA support
// - 02 enables, 82 disables write cache
// - AA enables, 55 disables read cache
// - 05 enables, 85 disables power management
// - 42 enables, C2 disables acoustic management
// - BB selects 4-byte ECC for long commands
// - 66 keeps, CC restores settings except write cache and acoustic state on soft reset
// - hard reset restores defaults except acoustic state, 66 survives soft reset
// - transfer mode type and number checked, else abort
// - acoustic state kept across hard and soft reset
`timescale 1ns/100ps
`default_nettype none
module afsr_core
  import afsr_pkg::*;
#(
  parameter int BUSY_CYCLES = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_hard_rst_n,
  input wire logic i_soft_rst,
  input wire afsr_bus_s i_bus,
  input wire afsr_strap_s i_strap,
  input wire logic [7:0] i_id_word_sel,
  output logic [7:0] o_rdata,
  output logic [15:0] o_id_word,
  output logic o_id_start,
  output logic o_intrq,
  output logic o_wcache_en,
  output logic o_rcache_en,
  output logic o_apm_en,
  output logic o_ecc4,
  output logic [7:0] o_xfer_mode
);
  // Reset-sense pins pass two flops first
  afsr_strap_s strap_meta_q;
  afsr_strap_s strap_q;
  logic hrst_meta_q;
  logic hrst_q;
  always_ff @(posedge i_ref_clk) begin
    strap_meta_q <= i_strap;
    strap_q <= strap_meta_q;
    hrst_meta_q <= ~i_hard_rst_n;
    hrst_q <= hrst_meta_q;
  end

  // Task-file registers
  logic [7:0] feature_q;
  logic [7:0] sector_count_q;
  logic [7:0] sector_index_q;
  logic [7:0] track_low_q;
  logic [7:0] track_high_q;
  logic [7:0] device_head_q;
  logic [7:0] fault_q;
  logic [7:0] status_q;
  afsr_state_e state_q;
  logic [7:0] cmd_q;
  logic [7:0] busy_cnt_q;
  logic cmd_wr;
  logic selected;

  // Unit select decode
  function automatic logic sel_match(input logic [7:0] dh, input logic unit1);
    sel_match = (dh[DH_UNIT] == unit1);
  endfunction : sel_match

  assign selected = sel_match(device_head_q, strap_q.unit1);
  assign cmd_wr = i_bus.wr && (i_bus.addr == OFS_COMMAND_CODE) && selected
    && !status_q[ST_BSY];

  // Host writes to the parameter registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || hrst_q) begin
      feature_q <= 8'h00;
      sector_count_q <= 8'h01;
      sector_index_q <= 8'h01;
      track_low_q <= 8'h00;
      track_high_q <= 8'h00;
      device_head_q <= 8'h00;
    end else if (i_bus.wr && !status_q[ST_BSY]) begin
      unique case (i_bus.addr)
        OFS_FEATURE_SELECT: feature_q <= i_bus.wdata;
        OFS_SECTOR_COUNT: sector_count_q <= i_bus.wdata;
        OFS_SECTOR_INDEX: sector_index_q <= i_bus.wdata;
        OFS_TRACK_LOW: track_low_q <= i_bus.wdata;
        OFS_TRACK_HIGH: track_high_q <= i_bus.wdata;
        OFS_DEVICE_HEAD: device_head_q <= i_bus.wdata;
        default: ;
      endcase
    end
  end

  // Feature code validity
  function automatic logic xfer_ok(input logic [7:0] sc);
    logic [2:0] m;
    m = sc[2:0];
    unique case (sc[7:3])
      XT_PIO_DEF: xfer_ok = (m == 3'h0);
      XT_PIO_FC: xfer_ok = (m <= XM_PIO_MAX);
      XT_MDMA: xfer_ok = (m <= XM_MDMA_MAX);
      XT_UDMA: xfer_ok = (m <= XM_UDMA_MAX);
      default: xfer_ok = 1'b0;
    endcase
  endfunction : xfer_ok

  function automatic logic feat_ok(input logic [7:0] fc, input logic [7:0] sc);
    unique case (fc)
      FC_XFER_MODE: feat_ok = xfer_ok(sc);
      8'h02, 8'h04, 8'h05, 8'h33, 8'h42, 8'h54, 8'h55, 8'h66, 8'h77, 8'h81,
      8'h82, 8'h84, 8'h85, 8'h88, 8'h89, 8'hAA, 8'hAB, 8'hBB, 8'hC2,
      8'hCC: feat_ok = 1'b1;
      default: feat_ok = 1'b0;
    endcase
  endfunction : feat_ok

  // Command sequencer: busy, then complete
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || hrst_q || i_soft_rst) begin
      state_q <= AFSR_IDLE;
      cmd_q <= 8'h00;
      busy_cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        AFSR_IDLE: if (cmd_wr) begin
          state_q <= AFSR_BUSY;
          cmd_q <= i_bus.wdata;
          busy_cnt_q <= 8'(BUSY_CYCLES);
        end
        AFSR_BUSY: if (busy_cnt_q <= 8'h01) begin
          state_q <= AFSR_DONE;
        end else begin
          busy_cnt_q <= busy_cnt_q - 8'h01;
        end
        AFSR_DONE: state_q <= AFSR_IDLE;
      endcase
    end
  end

  logic done;
  logic is_sf;
  logic is_id;
  logic sf_ok;
  assign done = (state_q == AFSR_DONE);
  assign is_sf = (cmd_q == CMD_SET_FEATURES);
  assign is_id = (cmd_q == CMD_IDENTIFY) || (cmd_q == CMD_IDENTIFY_DMA);
  assign sf_ok = feat_ok(feature_q, sector_count_q);

  // Status and fault registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || hrst_q || i_soft_rst) begin
      status_q <= RST_STATUS;
      fault_q <= 8'h00;
    end else if (cmd_wr) begin
      status_q <= 8'h80;
      fault_q <= 8'h00;
    end else if (done) begin
      status_q <= RST_STATUS;
      if (is_sf && !sf_ok) begin
        status_q[ST_ERR] <= 1'b1;
        fault_q[FR_ABRT] <= 1'b1;
      end else if (!is_sf && !is_id) begin
        status_q[ST_ERR] <= 1'b1;
        fault_q[FR_ABRT] <= 1'b1;
      end
    end
  end

  // Interrupt request: set on completion, cleared by status read
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || hrst_q || i_soft_rst) begin
      o_intrq <= 1'b0;
    end else if (done) begin
      o_intrq <= 1'b1;
    end else if (i_bus.rd && i_bus.addr == OFS_DRIVE_CONDITION || cmd_wr) begin
      o_intrq <= 1'b0;
    end
  end

  // Identify data phase starts for either identify code
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_id_start <= 1'b0;
    end else begin
      o_id_start <= done && is_id;
    end
  end

  // Feature settings
  logic apply;
  logic keep_q;
  assign apply = done && is_sf && sf_ok;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || hrst_q) begin
      o_wcache_en <= RST_WCACHE;
      o_rcache_en <= RST_RCACHE;
      o_apm_en <= RST_APM;
      o_ecc4 <= RST_ECC4;
      o_xfer_mode <= RST_XFER;
      keep_q <= RST_KEEP;
    end else if (i_soft_rst && !keep_q) begin
      o_rcache_en <= RST_RCACHE;
      o_apm_en <= RST_APM;
      o_ecc4 <= RST_ECC4;
      o_xfer_mode <= RST_XFER;
    end else if (apply) begin
      unique case (feature_q)
        FC_WCACHE_ON: o_wcache_en <= 1'b1;
        FC_WCACHE_OFF: o_wcache_en <= 1'b0;
        FC_RCACHE_ON: o_rcache_en <= 1'b1;
        FC_RCACHE_OFF: o_rcache_en <= 1'b0;
        FC_APM_ON: o_apm_en <= 1'b1;
        FC_APM_OFF: o_apm_en <= 1'b0;
        FC_ECC4: o_ecc4 <= 1'b1;
        FC_KEEP_ON_SRST: keep_q <= 1'b1;
        FC_REVERT_ON_SRST: keep_q <= 1'b0;
        FC_XFER_MODE: o_xfer_mode <= sector_count_q;
        default: ;
      endcase
    end
  end

  // Acoustic state, untouched by any reset except system reset
  logic aam_en_q;
  logic [7:0] aam_level_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      aam_en_q <= RST_AAM;
      aam_level_q <= RST_AAM_LEVEL;
    end else if (apply && feature_q == FC_AAM_ON) begin
      aam_en_q <= 1'b1;
      aam_level_q <= sector_count_q;
    end else if (apply && feature_q == FC_AAM_OFF) begin
      aam_en_q <= 1'b0;
      aam_level_q <= 8'h00;
    end
  end

  // Hardware reset result, captured only while hard reset runs
  logic [15:0] rr_q;
  logic [15:0] rr_d;
  always_comb begin
    rr_d = RR_FIXED;
    rr_d[RR_CABLE] = strap_q.cable80;
    if (strap_q.unit1) begin
      rr_d[7:0] = 8'h00;
      rr_d[12] = 1'b0;
      rr_d[RR_D1_PDIAG] = strap_q.pdiag;
      rr_d[RR_D1_METH +: 2] = strap_q.method;
    end else begin
      rr_d[12:8] = 5'h00;
      rr_d[RR_D0_RESP] = strap_q.resp_d1;
      rr_d[RR_D0_DASP] = strap_q.dasp;
      rr_d[RR_D0_PDIAG] = strap_q.pdiag;
      rr_d[RR_D0_DIAG] = strap_q.diag_ok;
      rr_d[RR_D0_METH +: 2] = strap_q.method;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rr_q <= RR_FIXED;
    end else if (hrst_q) begin
      rr_q[12:0] <= rr_d[12:0];
      rr_q[RR_CABLE] <= rr_d[RR_CABLE];
    end
  end

  // Identify word mux for words served here
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_id_word <= 16'h0000;
    end else begin
      unique case (i_id_word_sel)
        IDW_RESET: o_id_word <= rr_q;
        IDW_AAM: o_id_word <= {8'h00, aam_en_q ? aam_level_q : 8'h00};
        IDW_EN86: o_id_word <= 16'((32'(aam_en_q) << W86_AAM) | (32'(o_apm_en) << W86_APM));
        default: o_id_word <= 16'h0000;
      endcase
    end
  end

  // Task-file read data
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_bus.addr)
        OFS_FAULT_REPORT: o_rdata <= fault_q;
        OFS_SECTOR_COUNT: o_rdata <= sector_count_q;
        OFS_SECTOR_INDEX: o_rdata <= sector_index_q;
        OFS_TRACK_LOW: o_rdata <= track_low_q;
        OFS_TRACK_HIGH: o_rdata <= track_high_q;
        OFS_DEVICE_HEAD: o_rdata <= device_head_q;
        OFS_DRIVE_CONDITION: o_rdata <= status_q;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule : afsr_core
`default_nettype wire

// ---- tb/afsr_core_props.sv ----
// Checker: timing and report-word relations of the command block.
// Sees only the core ports; attached by the bind after the module.
`timescale 1ns/100ps
`default_nettype none
module afsr_core_props
  import afsr_pkg::*;
#(
  parameter int BUSY_CYCLES = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_hard_rst_n,
  input wire afsr_bus_s i_bus,
  input wire afsr_strap_s i_strap,
  input wire logic [7:0] i_id_word_sel,
  input wire logic [15:0] o_id_word,
  input wire logic o_intrq,
  input wire logic o_rcache_en,
  input wire logic o_apm_en,
  input wire logic o_ecc4,
  input wire logic [7:0] o_xfer_mode
);
  localparam int LAT = BUSY_CYCLES + 2;
  logic [7:0] fsel_q;
  logic [7:0] cnt_q;
  logic [2:0] hr_q;
  logic unit_at_rst_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Last feature and count the host wrote
  always_ff @(posedge i_ref_clk) begin
    if (i_bus.wr && i_bus.addr == OFS_FEATURE_SELECT) begin
      fsel_q <= i_bus.wdata;
    end
    if (i_bus.wr && i_bus.addr == OFS_SECTOR_COUNT) begin
      cnt_q <= i_bus.wdata;
    end
  end
  // Unit number that the last hard reset reported
  always_ff @(posedge i_ref_clk) begin
    if (!i_hard_rst_n) begin
      unit_at_rst_q <= i_strap.unit1;
    end
  end
  // Cycles since both resets were last released
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_hard_rst_n) begin
      hr_q <= 3'h0;
    end else if (hr_q != 3'h7) begin
      hr_q <= hr_q + 3'h1;
    end
  end
  chk_intrq_delay: assert property ($rose(o_intrq) |->
    $past(i_bus.wr && i_bus.addr == OFS_COMMAND_CODE, LAT)) else $error("intrq without command");
  chk_status_clear: assert property (i_bus.rd && i_bus.addr == OFS_DRIVE_CONDITION
    |=> !o_intrq) else $error("intrq kept after status read");
  chk_rcache_off: assert property ($fell(o_rcache_en) |->
    $rose(o_intrq) && fsel_q == FC_RCACHE_OFF) else $error("read cache dropped wrongly");
  chk_apm_on: assert property ($rose(o_apm_en) |->
    $rose(o_intrq) && fsel_q == FC_APM_ON) else $error("power management raised wrongly");
  chk_ecc_on: assert property ($rose(o_ecc4) |->
    $rose(o_intrq) && fsel_q == FC_ECC4) else $error("ecc length raised wrongly");
  chk_xfer_set: assert property ($changed(o_xfer_mode) && o_xfer_mode != 8'h00 |->
    $rose(o_intrq) && fsel_q == FC_XFER_MODE && o_xfer_mode == cnt_q) else $error("bad mode");
  chk_word_hold: assert property (hr_q == 3'h7 && $past(i_id_word_sel) == IDW_RESET &&
    $past(i_id_word_sel, 2) == IDW_RESET |-> $stable(o_id_word[12:0])) else $error("w93 moved");
  chk_unit0_zero: assert property (hr_q == 3'h7 && $past(i_id_word_sel) == IDW_RESET &&
    !unit_at_rst_q |-> o_id_word[12:8] == 5'h00) else $error("unit 0 high bits set");
  // Main scenarios reached
  cov_done: cover property ($rose(o_intrq));
  cov_rcache: cover property ($fell(o_rcache_en));
  cov_hold: cover property (hr_q == 3'h7 && i_id_word_sel == IDW_RESET);
endmodule : afsr_core_props
bind afsr_core afsr_core_props #(.BUSY_CYCLES(BUSY_CYCLES)) u_afsr_core_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hard_rst_n(i_hard_rst_n), .i_bus(i_bus),
  .i_strap(i_strap), .i_id_word_sel(i_id_word_sel), .o_id_word(o_id_word),
  .o_intrq(o_intrq), .o_rcache_en(o_rcache_en), .o_apm_en(o_apm_en), .o_ecc4(o_ecc4),
  .o_xfer_mode(o_xfer_mode));
`default_nettype wire

// ---- tb/afsr_host.sv ----
// Host adapter model: task-file writes, reads and command issue.
// Assumes strobes launched on falling edges, one cycle wide.
`timescale 1ns/100ps
`default_nettype none
module afsr_host
  import afsr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output var afsr_bus_s o_bus
);
  // Idle bus at time zero
  initial begin
    o_bus = '0;
  end
  // One-cycle write; released lines show inverted values
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_bus = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge i_ref_clk);
    o_bus = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
  endtask : wr_reg
  // One-cycle read; data taken one edge later
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_bus = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge i_ref_clk);
    d = i_rdata;
    o_bus = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 8'hFF};
  endtask : rd_reg
  // Feature, count, unit select, then command code
  task automatic cmd(input logic [7:0] fc, input logic [7:0] sc, input logic [7:0] code,
                     input logic unit);
    wr_reg(OFS_FEATURE_SELECT, fc);
    wr_reg(OFS_SECTOR_COUNT, sc);
    wr_reg(OFS_DEVICE_HEAD, {3'h5, unit, 4'h0});
    wr_reg(OFS_COMMAND_CODE, code);
  endtask : cmd
endmodule : afsr_host
`default_nettype wire

// ---- tb/test_ata_feature_set_and_reset_report.sv ----
// Testbench: feature command table, resets and reset-report words.
// Assumes the host model drives the task file on falling edges.
`timescale 1ns/100ps
`default_nettype none
module test_ata_feature_set_and_reset_report;
  import afsr_pkg::*;
  typedef struct packed {
    logic [7:0] fc;
    logic [7:0] sc;
    logic err;
    logic [3:0] set;
    logic [7:0] xm;
    logic [7:0] w94;
  } afsr_row_s;
  logic i_ref_clk, i_rst_n, i_hard_rst_n, i_soft_rst, o_id_start, o_intrq;
  logic o_wcache_en, o_rcache_en, o_apm_en, o_ecc4, id_seen;
  logic [7:0] i_id_word_sel, o_rdata, o_xfer_mode, fr, st;
  logic [15:0] o_id_word, w;
  afsr_bus_s bus;
  afsr_strap_s i_strap;
  int error_cnt, check_count, cyc;
  wire [7:0] sets = {4'h0, o_wcache_en, o_rcache_en, o_apm_en, o_ecc4};
  // Feature, count, abort, cache/apm/ecc, mode, acoustic word
  afsr_row_s rows [15] = '{
    '{8'h42, 8'hC0, 1'h0, 4'hC, 8'h00, 8'hC0}, '{8'h82, 8'h00, 1'h0, 4'h4, 8'h00, 8'hC0},
    '{8'h02, 8'h00, 1'h0, 4'hC, 8'h00, 8'hC0}, '{8'h55, 8'h00, 1'h0, 4'h8, 8'h00, 8'hC0},
    '{8'hAA, 8'h00, 1'h0, 4'hC, 8'h00, 8'hC0}, '{8'h05, 8'h00, 1'h0, 4'hE, 8'h00, 8'hC0},
    '{8'h85, 8'h00, 1'h0, 4'hC, 8'h00, 8'hC0}, '{8'hBB, 8'h00, 1'h0, 4'hD, 8'h00, 8'hC0},
    '{8'h03, 8'h0C, 1'h0, 4'hD, 8'h0C, 8'hC0}, '{8'h03, 8'h45, 1'h0, 4'hD, 8'h45, 8'hC0},
    '{8'h03, 8'h0D, 1'h1, 4'hD, 8'h45, 8'hC0}, '{8'h03, 8'h23, 1'h1, 4'hD, 8'h45, 8'hC0},
    '{8'h03, 8'h22, 1'h0, 4'hD, 8'h22, 8'hC0}, '{8'hC2, 8'h00, 1'h0, 4'hD, 8'h22, 8'h00},
    '{8'h13, 8'h00, 1'h1, 4'hD, 8'h22, 8'h00}};
  afsr_core u_afsr_core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hard_rst_n(i_hard_rst_n),
    .i_soft_rst(i_soft_rst), .i_bus(bus), .i_strap(i_strap), .i_id_word_sel(i_id_word_sel),
    .o_rdata(o_rdata), .o_id_word(o_id_word), .o_id_start(o_id_start), .o_intrq(o_intrq),
    .o_wcache_en(o_wcache_en), .o_rcache_en(o_rcache_en), .o_apm_en(o_apm_en),
    .o_ecc4(o_ecc4), .o_xfer_mode(o_xfer_mode));
  afsr_host u_afsr_host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .o_bus(bus));
  // Clock at 100 MHz
  initial begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Identify pulse catcher and hang guard
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_id_start === 1'h1) id_seen <= 1'h1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  // Issue, see busy, wait for interrupt, read fault then status
  task automatic run_cmd(input logic [7:0] fc, input logic [7:0] sc, input logic [7:0] code);
    u_afsr_host.cmd(fc, sc, code, i_strap.unit1);
    u_afsr_host.rd_reg(OFS_DRIVE_CONDITION, st);
    chk_byte("busy", 8'h80, st);
    for (int k = 0; k < 20 && o_intrq !== 1'h1; k++) @(negedge i_ref_clk);
    chk_byte("intrq", 8'h01, {7'h0, o_intrq});
    u_afsr_host.rd_reg(OFS_FAULT_REPORT, fr);
    u_afsr_host.rd_reg(OFS_DRIVE_CONDITION, st);
    chk_byte("intrq clear", 8'h00, {7'h0, o_intrq});
  endtask : run_cmd
  task automatic rd_id(input logic [7:0] s);
    @(negedge i_ref_clk);
    i_id_word_sel = s;
    @(negedge i_ref_clk);
    w = o_id_word;
  endtask : rd_id
  task automatic pulse(input logic hard);
    @(negedge i_ref_clk);
    if (hard) i_hard_rst_n = 1'h0;
    else i_soft_rst = 1'h1;
    repeat (6) @(negedge i_ref_clk);
    i_hard_rst_n = 1'h1;
    i_soft_rst = 1'h0;
    repeat (8) @(negedge i_ref_clk);
  endtask : pulse
  task automatic end_sim;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    i_rst_n = 1'h0;
    i_hard_rst_n = 1'h1;
    i_soft_rst = 1'h0;
    i_id_word_sel = IDW_AAM;
    i_strap = '{1'h0, 2'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    id_seen = 1'h0;
    repeat (4) @(negedge i_ref_clk);
    i_rst_n = 1'h1;
    u_afsr_host.rd_reg(OFS_DRIVE_CONDITION, st);
    chk_byte("status", RST_STATUS, st);
    chk_byte("defaults", 8'h0C, sets);
    foreach (rows[i]) begin
      run_cmd(rows[i].fc, rows[i].sc, CMD_SET_FEATURES);
      chk_byte("status", {7'h28, rows[i].err}, st);
      chk_byte("fault", {5'h0, rows[i].err, 2'h0}, fr);
      chk_byte("settings", {4'h0, rows[i].set}, sets);
      chk_byte("xfer", rows[i].xm, o_xfer_mode);
      rd_id(IDW_AAM);
      chk_word("w94", {8'h00, rows[i].w94}, w);
    end
    // Soft reset with keep, then with revert
    run_cmd(FC_AAM_ON, 8'h90, CMD_SET_FEATURES);
    run_cmd(FC_RCACHE_OFF, 8'h00, CMD_SET_FEATURES);
    run_cmd(FC_KEEP_ON_SRST, 8'h00, CMD_SET_FEATURES);
    pulse(1'h0);
    chk_byte("kept", 8'h09, sets);
    chk_byte("xfer kept", 8'h22, o_xfer_mode);
    run_cmd(FC_REVERT_ON_SRST, 8'h00, CMD_SET_FEATURES);
    pulse(1'h0);
    chk_byte("reverted", 8'h0C, sets);
    // Hard reset as unit 0
    run_cmd(FC_RCACHE_OFF, 8'h00, CMD_SET_FEATURES);
    pulse(1'h1);
    chk_byte("hard", 8'h0C, sets);
    rd_id(IDW_AAM);
    chk_word("w94 kept", 16'h0090, w);
    rd_id(IDW_RESET);
    chk_word("w93", 16'h605B, w);
    i_strap = '{1'h1, 2'h2, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
    rd_id(IDW_RESET);
    chk_word("w93 hold", 16'h605B, w);
    // Hard reset as unit 1, then identify by the plain and the DMA code
    pulse(1'h1);
    rd_id(IDW_RESET);
    chk_word("w93 unit1", 16'h4C00, w);
    run_cmd(8'h00, 8'h00, CMD_IDENTIFY);
    chk_byte("identify plain", 8'h01, {7'h0, id_seen});
    id_seen = 1'h0;
    run_cmd(8'h00, 8'h00, CMD_IDENTIFY_DMA);
    chk_byte("identify", 8'h01, {7'h0, id_seen});
    chk_byte("id status", RST_STATUS, st);
    chk_byte("id fault", 8'h00, fr);
    rd_id(IDW_EN86);
    chk_word("w86", 16'h0200, w);
    end_sim();
  end
endmodule : test_ata_feature_set_and_reset_report
`default_nettype wire
